//--- rtl/nic_core.sv
// Nested interrupt controller core facing the CPU sequencer.
`timescale 1ns/1ps
// How it works
// - Sixteen vectors FFE0h to FFFFh; the serviced source's vector goes out.
// - Current level lives in condition code bits 5 and 3.
// - Condition code resets to 111x1010, giving level 3.
// - Entry waits for the CPU to end its current instruction.
// - Entry asks the CPU to push program counter, X, A and CC.
// - Entry loads the level bits from the serviced vector priority.
// - After stacking the program counter takes the vector address.
// - Return restores the popped level bits.
// - Highest software level wins, ties go to fixed hardware order.
// - Unserved edge requests stay latched until they win or their clearing sequence drops them.
// - Top pin, reset and trap beat every software level.
// - Reset and top pin ignore the mask, set level 3, wake halt.
// - Reset is highest and its routine runs at level 3.
// - Trap instruction raises trap; top pin can preempt its routine.
// - Maskable source needs enable and a strictly higher level.
// - Top pin edge raises a trap-like interrupt.
// - Edge external requests latch and clear on entry.
// - Grouped pins of one line are ORed together.
// - Peripheral request is flag AND enable.
// - Clearing sequence drops the latched request.
// - Any source wakes wait; only halt-capable ones wake halt.
// - On halt exit the first serviced source is halt-capable.
// - Writes of the level 0 code to a priority field are ignored.
// - Top pin, reset and trap entry set both level bits.
module nic_core (
    input wire logic clk, // 200 MHz CPU clock
    input wire logic reset_n, // Asynchronous active-low reset
    input wire nic_pkg::nic_bus_t bus, // Register strobes and address
    output logic [7:0] rdata, // Read data, one cycle after read
    input wire logic top_pin, // Top-level interrupt pin, async
    input wire logic top_rise_sel, // 1 rising, 0 falling edge on top pin
    input wire logic [3:0] ext_pins, // ORed external pin groups, async
    input wire logic [7:0] periph_flag, // Peripheral status flags
    input wire logic [7:0] periph_en, // Peripheral enable bits
    input wire logic [13:0] src_clear, // Clearing sequence per source
    input wire logic instr_done, // Current instruction completes
    input wire logic trap_instr, // Trap instruction executed
    input wire logic irq_return_instr_instr, // Return pops CC
    input wire logic [7:0] popped_cc, // CC value popped on return
    input wire logic cc_load, // CPU writes flags or level bits
    input wire logic [7:0] cc_wdata, // Value for CC load
    input wire logic stack_done, // CPU finished pushing registers
    input wire logic in_wait, // CPU is in wait mode
    input wire logic in_halt, // CPU is in halt mode
    output logic [7:0] cc_out, // Condition code register
    output logic stack_req, // Ask CPU to push PC, X, A, CC
    output logic fetch_req, // Load PC from vector_addr
    output logic [15:0] vector_addr, // Vector of serviced source
    output logic wake // Leave wait or halt
);
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [1:0] top_sync_ff;
    logic top_last_ff;
    logic [3:0] ext_s1_ff, ext_s2_ff, ext_last_ff;
    logic [7:0] prio_ff [nic_pkg::NUM_PRIO_REGS];
    logic [7:0] cc_ff;
    logic [13:0] pend_ff;
    logic top_pend_ff, trap_pend_ff;
    logic halt_first_ff;
    nic_pkg::nic_state_t state_ff, nxt_state;
    nic_pkg::nic_entry_t entry_ff, nxt_entry;
    logic [13:0] entry_src_ff, nxt_entry_src;
    logic [13:0] req;
    logic [1:0] cur_lvl;
    logic [2:0] cur_rank;
    logic [2:0] src_rank [14];
    logic top_edge;
    logic [3:0] ext_edge;
    logic [7:0] rdata_ff;

    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            top_sync_ff <= 2'h0;
            top_last_ff <= 1'b0;
            ext_s1_ff <= 4'h0;
            ext_s2_ff <= 4'h0;
            ext_last_ff <= 4'h0;
        end else begin
            top_sync_ff <= {top_sync_ff[0], top_pin};
            top_last_ff <= top_sync_ff[1];
            ext_s1_ff <= ext_pins;
            ext_s2_ff <= ext_s1_ff;
            ext_last_ff <= ext_s2_ff;
        end
    end
    // Edge sensitivity of the groups is fixed to rising in this core.
    assign top_edge = top_rise_sel ? (top_sync_ff[1] & ~top_last_ff) :
                      (~top_sync_ff[1] & top_last_ff);
    assign ext_edge = ext_s2_ff & ~ext_last_ff;

    // ------------------------------------------------------------
    // Request latches
    // ------------------------------------------------------------
    always_comb begin
        req = pend_ff;
        req[0] = 1'b0;
        req[13:6] = periph_flag & periph_en;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= 14'h0;
        end else begin
            for (int i = 0; i < 14; i++) begin
                if (nic_pkg::EDGE_SRC_MASK[i] && ext_edge[2'(i + 2)]) begin
                    pend_ff[i] <= 1'b1;
                end else if (src_clear[i] ||
                             (state_ff == nic_pkg::ST_FETCH &&
                              entry_src_ff[i])) begin
                    pend_ff[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            top_pend_ff <= 1'b0;
            trap_pend_ff <= 1'b0;
        end else begin
            if (top_edge) begin
                top_pend_ff <= 1'b1;
            end else if (state_ff == nic_pkg::ST_FETCH &&
                         entry_ff.vector == nic_pkg::VEC_TOP) begin
                top_pend_ff <= 1'b0;
            end
            if (trap_instr) begin
                trap_pend_ff <= 1'b1;
            end else if (state_ff == nic_pkg::ST_FETCH &&
                         entry_ff.vector == nic_pkg::VEC_TRAP) begin
                trap_pend_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    function automatic logic [2:0] lvl_rank(input logic [1:0] c);
        unique case (c)
            nic_pkg::LVL0: lvl_rank = 3'h0;
            nic_pkg::LVL1: lvl_rank = 3'h1;
            nic_pkg::LVL2: lvl_rank = 3'h2;
            default: lvl_rank = 3'h3;
        endcase
    endfunction

    assign cur_lvl = {cc_ff[nic_pkg::CC_PRIO_HI_POS],
                      cc_ff[nic_pkg::CC_PRIO_LO_POS]};
    assign cur_rank = lvl_rank(cur_lvl);

    genvar g;
    generate
        for (g = 0; g < 14; g++) begin : g_rank
            assign src_rank[g] = lvl_rank(prio_ff[g/4][(g%4)*2 +: 2]);
        end
    endgenerate

    always_comb begin
        logic [2:0] best;
        logic found;
        best = 3'h0;
        found = 1'b0;
        nxt_entry = entry_ff;
        nxt_entry_src = 14'h0;
        nxt_state = state_ff;
        unique case (state_ff)
            nic_pkg::ST_RESET: begin
                nxt_entry = '{nic_pkg::VEC_RESET, nic_pkg::LVL3, 1'b0};
                nxt_state = nic_pkg::ST_FETCH;
            end
            nic_pkg::ST_RUN: begin
                if (instr_done) begin
                    if (trap_pend_ff || trap_instr) begin
                        nxt_entry = '{nic_pkg::VEC_TRAP, nic_pkg::LVL3, 1'b1};
                        found = 1'b1;
                    end else if (top_pend_ff) begin
                        nxt_entry = '{nic_pkg::VEC_TOP, nic_pkg::LVL3, 1'b1};
                        found = 1'b1;
                    end
                    // Lowest index first gives the fixed hardware order.
                    for (int i = 13; i >= 1; i--) begin
                        if (!found && req[i] &&
                            src_rank[i] > cur_rank &&
                            src_rank[i] >= best &&
                            (!halt_first_ff ||
                             nic_pkg::HALT_WAKE_MASK[i])) begin
                            best = src_rank[i];
                            nxt_entry_src = 14'h0;
                            nxt_entry_src[i] = 1'b1;
                            nxt_entry.vector = nic_pkg::VEC_BASE_HI -
                                16'(2 * i);
                            nxt_entry.new_level = prio_ff[i/4][(i%4)*2 +: 2];
                            nxt_entry.stack_regs = 1'b1;
                        end
                    end
                    if (found || nxt_entry_src != 14'h0) begin
                        nxt_state = nic_pkg::ST_STACK;
                    end
                end
            end
            nic_pkg::ST_STACK: begin
                nxt_entry_src = entry_src_ff;
                if (stack_done) begin
                    nxt_state = nic_pkg::ST_FETCH;
                end
            end
            nic_pkg::ST_FETCH: begin
                nxt_state = nic_pkg::ST_RUN;
            end
            default: nxt_state = nic_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= nic_pkg::ST_RESET;
            entry_ff <= '0;
            entry_src_ff <= 14'h0;
        end else begin
            state_ff <= nxt_state;
            entry_ff <= nxt_entry;
            entry_src_ff <= nxt_entry_src;
        end
    end

    // Halt exit forces the first entry to a halt-capable source only.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_first_ff <= 1'b0;
        end else if (in_halt) begin
            halt_first_ff <= 1'b1;
        end else if (state_ff == nic_pkg::ST_FETCH) begin
            halt_first_ff <= 1'b0;
        end
    end

    assign wake = (in_wait && (req[13:1] != 13'h0 || top_pend_ff)) ||
                  (in_halt && ((req & nic_pkg::HALT_WAKE_MASK) != 14'h0 ||
                   top_pend_ff));

    // ------------------------------------------------------------
    // Condition code register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cc_ff <= nic_pkg::CC_RESET;
        end else if (state_ff == nic_pkg::ST_FETCH) begin
            cc_ff[nic_pkg::CC_PRIO_HI_POS] <= entry_ff.new_level[1];
            cc_ff[nic_pkg::CC_PRIO_LO_POS] <= entry_ff.new_level[0];
        end else if (irq_return_instr_instr) begin
            cc_ff <= popped_cc;
        end else if (cc_load) begin
            cc_ff <= cc_wdata;
        end else if (bus.wr && bus.addr == nic_pkg::ADDR_CC) begin
            cc_ff <= bus.wdata;
        end
    end

    assign cc_out = cc_ff;
    assign stack_req = (state_ff == nic_pkg::ST_STACK) && entry_ff.stack_regs;
    assign fetch_req = (state_ff == nic_pkg::ST_FETCH);
    assign vector_addr = entry_ff.vector;

    // ------------------------------------------------------------
    // Software priority registers and read port
    // ------------------------------------------------------------
    generate
        for (g = 0; g < nic_pkg::NUM_PRIO_REGS; g++) begin : g_prio
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    prio_ff[g] <= nic_pkg::PRIO_REG_RESET;
                end else if (bus.wr && bus.addr == 3'(g)) begin
                    for (int f = 0; f < 4; f++) begin
                        if (bus.wdata[f*2 +: 2] != nic_pkg::LVL0 &&
                            !(g == 3 && f >= 2)) begin
                            prio_ff[g][f*2 +: 2] <= bus.wdata[f*2 +: 2];
                        end
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                3'h0, 3'h1, 3'h2, 3'h3: rdata_ff <= prio_ff[bus.addr[1:0]];
                nic_pkg::ADDR_CC: rdata_ff <= cc_ff;
                nic_pkg::ADDR_PEND_LO: rdata_ff <= req[7:0];
                nic_pkg::ADDR_PEND_HI: rdata_ff <= {2'h0, req[13:8]};
                default: rdata_ff <= {2'h0, top_pend_ff, trap_pend_ff,
                                      state_ff};
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end
    assign rdata = rdata_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_reset_lvl;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == nic_pkg::ST_FETCH && entry_ff.vector == nic_pkg::VEC_RESET)
        |=> (cc_ff[5] && cc_ff[3]);
    endproperty
    a_reset_lvl: assert property (p_reset_lvl) else $error("reset level");
    property p_entry_lvl;
        @(posedge clk) disable iff (!rst_n)
        fetch_req |=> {cc_ff[5], cc_ff[3]} == $past(entry_ff.new_level);
    endproperty
    a_entry_lvl: assert property (p_entry_lvl) else $error("entry level");
    property p_wait_done;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == nic_pkg::ST_RUN && !instr_done) |=>
        state_ff != nic_pkg::ST_STACK;
    endproperty
    a_wait_done: assert property (p_wait_done) else $error("early entry");
    property p_fetch_after_stack;
        @(posedge clk) disable iff (!rst_n)
        (stack_req && stack_done) |=> fetch_req ##1 !fetch_req;
    endproperty
    a_fetch_after_stack: assert property (p_fetch_after_stack)
        else $error("fetch");
    property p_irq_return_instr;
        @(posedge clk) disable iff (!rst_n)
        (irq_return_instr_instr && state_ff != nic_pkg::ST_FETCH) |=>
        cc_ff == $past(popped_cc);
    endproperty
    a_irq_return_instr: assert property (p_irq_return_instr) else $error("irq_return_instr restore");
    property p_trap_vec;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == nic_pkg::ST_RUN && instr_done && trap_instr) |=>
        stack_req && vector_addr == nic_pkg::VEC_TRAP;
    endproperty
    a_trap_vec: assert property (p_trap_vec) else $error("trap");
    property p_edge_clear;
        @(posedge clk) disable iff (!rst_n)
        (fetch_req && entry_src_ff[2] && !ext_edge[0]) |=> !pend_ff[2];
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("edge clr");
    property p_vec_range;
        @(posedge clk) disable iff (!rst_n)
        fetch_req |-> vector_addr[15:5] == 11'h7FF;
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector");
endmodule // nic_core

//--- shared/nic_pkg.sv
// Package for the nested interrupt controller: constants, types, states.
package nic_pkg;
    localparam int NUM_SRC = 14;
    localparam int NUM_PRIO_REGS = 4;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP = 16'hFFFC;
    localparam logic [15:0] VEC_TOP = 16'hFFFA;
    localparam logic [15:0] VEC_BASE_HI = 16'hFFFA;
    localparam logic [7:0] CC_RESET = 8'hEA;
    localparam int CC_PRIO_HI_POS = 5;
    localparam int CC_PRIO_LO_POS = 3;
    localparam logic [1:0] LVL0 = 2'h2;
    localparam logic [1:0] LVL1 = 2'h1;
    localparam logic [1:0] LVL2 = 2'h0;
    localparam logic [1:0] LVL3 = 2'h3;
    localparam logic [7:0] PRIO_REG_RESET = 8'hFF;
    localparam logic [7:0] PRIO_REG3_RO = 8'hF0;
    localparam logic [2:0] ADDR_PRIO0 = 3'h0;
    localparam logic [2:0] ADDR_CC = 3'h4;
    localparam logic [2:0] ADDR_PEND_LO = 3'h5;
    localparam logic [2:0] ADDR_PEND_HI = 3'h6;
    localparam logic [2:0] ADDR_STATUS = 3'h7;
    localparam logic [13:0] HALT_WAKE_MASK = 14'h20BF;
    localparam logic [13:0] EDGE_SRC_MASK = 14'h003C;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } nic_bus_t;

    typedef struct packed {
        logic [15:0] vector;
        logic [1:0] new_level;
        logic stack_regs;
    } nic_entry_t;

    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_STACK = 4'b0010,
        ST_FETCH = 4'b0100,
        ST_RESET = 4'b1000
    } nic_state_t;
endpackage

//--- sim/nic_cpu_model.sv
// CPU sequencer model: instruction ends, stacking handshake and a CC stack.
`timescale 1ns/1ps
module nic_cpu_model (
    input wire logic clk, // CPU clock
    input wire logic reset_n, // Active-low reset
    input wire logic hold, // Stop ending instructions
    input wire logic slow, // Stretch the stacking handshake
    input wire logic trap_go, // Run a trap instruction next
    input wire logic irq_return_instr_go, // Run a return instruction next
    input wire logic stack_req, // Push request from the controller
    input wire logic [7:0] cc_out, // Condition code to push
    output logic instr_done, // Instruction end pulse
    output logic trap_instr, // Trap executed
    output logic irq_return_instr_instr, // Return executed
    output logic stack_done, // Push finished
    output logic [7:0] popped_cc // CC popped on return
);
    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic [7:0] stk_ff [0:3];
    logic [1:0] sp_ff;
    logic [1:0] dly_ff;
    logic ph_ff;
    logic trap_pend_ff;
    logic irq_return_instr_pend_ff;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {ph_ff, trap_pend_ff, irq_return_instr_pend_ff} <= 3'h0;
            {instr_done, trap_instr, irq_return_instr_instr, stack_done} <= 4'h0;
            sp_ff <= 2'h0;
            dly_ff <= 2'h0;
            popped_cc <= 8'h00;
        end else begin
            ph_ff <= ~ph_ff;
            {instr_done, trap_instr, irq_return_instr_instr, stack_done} <= 4'h0;
            // Outside a return the popped value is not held, so a design
            // that reads it at the wrong time sees garbage.
            popped_cc <= ~popped_cc;
            if (trap_go) trap_pend_ff <= 1'h1;
            if (irq_return_instr_go) irq_return_instr_pend_ff <= 1'h1;
            if (stack_req && !stack_done) begin
                dly_ff <= dly_ff + 2'h1;
                if (dly_ff == (slow ? 2'h3 : 2'h0)) begin
                    stack_done <= 1'h1;
                    stk_ff[sp_ff] <= cc_out;
                    sp_ff <= sp_ff + 2'h1;
                    dly_ff <= 2'h0;
                end
            end else if (!hold && ph_ff && !stack_done) begin
                instr_done <= 1'h1;
                if (trap_pend_ff) begin
                    trap_instr <= 1'h1;
                    trap_pend_ff <= 1'h0;
                end else if (irq_return_instr_pend_ff && sp_ff != 2'h0) begin
                    irq_return_instr_instr <= 1'h1;
                    popped_cc <= stk_ff[sp_ff - 2'h1];
                    sp_ff <= sp_ff - 2'h1;
                    irq_return_instr_pend_ff <= 1'h0;
                end
            end
        end
    end
endmodule // nic_cpu_model

//--- sim/tb_top.sv
// Self-checking testbench for the nested interrupt controller core.
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } nic_row_t;
    logic clk, reset_n, top_pin, top_rise_sel, instr_done, trap_instr;
    logic irq_return_instr_instr, cc_load, stack_done, in_wait, in_halt, stack_req;
    logic fetch_req, wake, hold, slow, trap_go, irq_return_instr_go;
    logic [3:0] ext_pins;
    logic [13:0] src_clear;
    logic [7:0] rdata, periph_flag, periph_en, popped_cc, cc_wdata;
    logic [7:0] cc_out, rd_v;
    logic [15:0] vector_addr;
    nic_pkg::nic_bus_t bus;
    int err_total, n_checks;
    nic_row_t rows [4] = '{'{3'h0, 8'hCF, 8'hCF}, '{3'h0, 8'h64, 8'h44},
        '{3'h1, 8'hAA, 8'hFF}, '{3'h3, 8'h00, 8'hF0}};

    nic_core i_nic_core (.clk(clk), .reset_n(reset_n), .bus(bus),
        .rdata(rdata), .top_pin(top_pin), .top_rise_sel(top_rise_sel),
        .ext_pins(ext_pins), .periph_flag(periph_flag),
        .periph_en(periph_en), .src_clear(src_clear),
        .instr_done(instr_done), .trap_instr(trap_instr),
        .irq_return_instr_instr(irq_return_instr_instr), .popped_cc(popped_cc), .cc_load(cc_load),
        .cc_wdata(cc_wdata), .stack_done(stack_done), .in_wait(in_wait),
        .in_halt(in_halt), .cc_out(cc_out), .stack_req(stack_req),
        .fetch_req(fetch_req), .vector_addr(vector_addr), .wake(wake));
    nic_cpu_model i_nic_cpu_model (.clk(clk), .reset_n(reset_n),
        .hold(hold), .slow(slow), .trap_go(trap_go), .irq_return_instr_go(irq_return_instr_go),
        .stack_req(stack_req), .cc_out(cc_out), .instr_done(instr_done),
        .trap_instr(trap_instr), .irq_return_instr_instr(irq_return_instr_instr),
        .stack_done(stack_done), .popped_cc(popped_cc));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'h1, 1'h0};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'h0, 1'h1};
        @(posedge clk);
        bus <= '0;
        #1 d = rdata;
    endtask
    // Bounded wait on a one-cycle pulse; running out ends the run.
    task automatic wait_hi(input logic sel);
        int i;
        for (i = 0; i < 60 && (sel ? irq_return_instr_instr : fetch_req) !== 1'h1; i++)
            tick(1);
        if (i >= 60) begin
            err_total++;
            report_and_stop();
        end
    endtask
    task automatic entry(input logic [15:0] v);
        wait_hi(1'h0);
        check(vector_addr, v);
        tick(1);
    endtask
    task automatic lvl(input logic [1:0] e);
        check({14'h0, cc_out[5], cc_out[3]}, {14'h0, e});
    endtask
    task automatic go(input logic t);
        @(posedge clk);
        if (t) trap_go <= 1'h1;
        else irq_return_instr_go <= 1'h1;
        @(posedge clk);
        {trap_go, irq_return_instr_go} <= 2'h0;
        if (!t) begin
            wait_hi(1'h1);
            tick(1);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            tick(1);
            check({15'h0, stack_req}, 16'h0000);
        end
    endtask
    task automatic ext_pulse;
        @(posedge clk);
        ext_pins <= 4'h1;
        repeat (4) @(posedge clk);
        ext_pins <= 4'h0;
    endtask
    task automatic clear_src(input logic [13:0] m);
        @(posedge clk);
        src_clear <= m;
        @(posedge clk);
        src_clear <= 14'h0000;
    endtask
    task automatic wk(input logic e);
        tick(2);
        check({15'h0, wake}, {15'h0, e});
    endtask

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {reset_n, top_pin, cc_load, in_wait, in_halt} = 5'h00;
        {hold, slow, trap_go, irq_return_instr_go, top_rise_sel} = 5'h01;
        {bus, ext_pins, src_clear} = '0;
        {periph_flag, periph_en, cc_wdata} = 24'h000000;
        err_total = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        reset_n <= 1'h1;
        entry(nic_pkg::VEC_RESET);
        check({8'h0, cc_out & 8'hEF}, {8'h0, nic_pkg::CC_RESET & 8'hEF});
        bus_rd(3'h2, rd_v);
        check({8'h0, rd_v}, {8'h0, nic_pkg::PRIO_REG_RESET});
        foreach (rows[k]) begin
            bus_wr(rows[k].a, rows[k].d);
            bus_rd(rows[k].a, rd_v);
            check({8'h0, rd_v}, {8'h0, rows[k].e});
        end
        // A trap routine at level 3 is still preempted by the top pin.
        go(1'h1);
        entry(nic_pkg::VEC_TRAP);
        lvl(nic_pkg::LVL3);
        @(posedge clk) top_pin <= 1'h1;
        entry(nic_pkg::VEC_TOP);
        lvl(nic_pkg::LVL3);
        go(1'h0);
        go(1'h0);
        lvl(nic_pkg::LVL3);
        // A latched edge dropped by its clearing pulse is never served.
        ext_pulse();
        top_pin <= 1'h0;
        clear_src(14'h0004);
        @(posedge clk) {cc_load, cc_wdata} <= 9'h1E2;
        @(posedge clk) cc_load <= 1'h0;
        idle(12);
        bus_wr(3'h1, 8'h7F);
        bus_wr(3'h2, 8'hFC);
        hold <= 1'h1;
        ext_pulse();
        {periph_en, periph_flag} <= 16'h0602;
        @(posedge clk) hold <= 1'h0;
        entry(16'hFFF6);
        lvl(nic_pkg::LVL2);
        idle(10);
        bus_rd(nic_pkg::ADDR_PEND_LO, rd_v);
        check({8'h0, rd_v}, 16'h0080);
        go(1'h0);
        entry(16'hFFEC);
        lvl(nic_pkg::LVL1);
        periph_flag <= 8'h00;
        clear_src(14'h0080);
        go(1'h0);
        lvl(nic_pkg::LVL0);
        idle(8);
        // Halt exit: the halt-capable source goes first, then the other.
        {hold, slow, in_halt} <= 3'h7;
        periph_flag <= 8'h04;
        wk(1'h0);
        {in_halt, in_wait} <= 2'h1;
        wk(1'h1);
        {in_halt, in_wait} <= 2'h2;
        periph_flag <= 8'h06;
        wk(1'h1);
        {in_halt, hold} <= 2'h0;
        entry(16'hFFEC);
        lvl(nic_pkg::LVL1);
        entry(16'hFFEA);
        lvl(nic_pkg::LVL2);
        periph_flag <= 8'h00;
        clear_src(14'h0180);
        go(1'h0);
        lvl(nic_pkg::LVL1);
        go(1'h0);
        lvl(nic_pkg::LVL0);
        // Falling-edge select: a rise on the top pin is ignored, a fall taken.
        top_rise_sel <= 1'h0;
        @(posedge clk) top_pin <= 1'h1;
        idle(6);
        top_pin <= 1'h0;
        entry(nic_pkg::VEC_TOP);
        lvl(nic_pkg::LVL3);
        go(1'h0);
        lvl(nic_pkg::LVL0);
        report_and_stop();
    end
endmodule // tb_top
